// ===== pkg/fsr_map.svh
// Named offsets, bit positions, command codes and reset values of the status path.
// Assumes inclusion by bare name from the package and the test bench.
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH

// ----------------------------------------------------------------
// Status byte layout
// ----------------------------------------------------------------
`define FSR_STAT_RESET 8'h80
`define FSR_STAT_READY 7
`define FSR_STAT_ERASE_PAUSED 6
`define FSR_STAT_ERASE_FAIL 5
`define FSR_STAT_PROG_FAIL 4
`define FSR_STAT_SUPPLY_LOW 3
`define FSR_STAT_PROG_PAUSED 2
`define FSR_STAT_LOCK_ABORT 1
`define FSR_STAT_FACTORY_BUSY 0
`define FSR_UPPER_ZERO 8'h00
`define FSR_STICKY_CLEAR 4'h0

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define FSR_CMD_READ_STATUS 8'h70
`define FSR_CMD_READ_ARRAY 8'hff
`define FSR_CMD_CLEAR_STATUS 8'h50
`define FSR_CMD_PROG_SETUP 8'h40
`define FSR_CMD_PROT_SETUP 8'hc0
`define FSR_CMD_ERASE_SETUP 8'h20
`define FSR_CMD_LOCK_SETUP 8'h60
`define FSR_CMD_FACTORY_SETUP 8'h80
`define FSR_CMD_CONFIRM 8'hd0
`define FSR_CMD_SUSPEND 8'hb0
`define FSR_CMD_LOCK 8'h01
`define FSR_CMD_LOCK_DOWN 8'h2f
`define FSR_CMD_CONFIG 8'h03

// ----------------------------------------------------------------
// Synchronised pin vector
// ----------------------------------------------------------------
`define FSR_PIN_CE 0
`define FSR_PIN_OE 1
`define FSR_PIN_WE 2
`define FSR_PIN_ADV 3
`define FSR_PIN_DQ_LSB 4
`define FSR_PIN_DQ_MSB 19
`define FSR_PIN_IDLE 20'h0000f

`endif

// ===== pkg/fsr_pkg.sv
// Types shared by the status path modules.
// Assumes fsr_map.svh is reachable on the include path.
`include "fsr_map.svh"

package fsr_pkg;
  typedef logic [7:0] fsr_status_t;
  typedef logic [15:0] fsr_word_t;
  typedef logic [19:0] fsr_pins_t;

  typedef enum logic [5:0] {
    DS_IDLE = 6'b000001,
    DS_PROG = 6'b000010,
    DS_PROT = 6'b000100,
    DS_ERASE = 6'b001000,
    DS_LOCK = 6'b010000,
    DS_FACTORY = 6'b100000
  } fsr_dec_e;

  // Command byte compare, used throughout the decoder
  function automatic logic fsr_is_code(input logic [7:0] cmd, input logic [7:0] code);
    return cmd == code;
  endfunction : fsr_is_code
endpackage : fsr_pkg

// ===== pkg/fsr_pin_if.sv
// Clean pin levels and edge pulses from the synchroniser to the status logic.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none

interface fsr_pin_if;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic adv_n;
  logic [15:0] dq;
  logic ce_fall;
  logic ce_rise;
  logic oe_fall;
  logic adv_fall;
  logic we_rise;

  modport src (output ce_n, oe_n, we_n, adv_n, dq, ce_fall, ce_rise, oe_fall, adv_fall,
    we_rise);
  modport dst (input ce_n, oe_n, we_n, adv_n, dq, ce_fall, ce_rise, oe_fall, adv_fall,
    we_rise);
endinterface : fsr_pin_if

`default_nettype wire

// ===== design/fsr_pin_sync.sv
// Three-stage synchroniser with agreement filter for the flash bus pins.
// Assumes raw pins are asynchronous to clk; outputs one edge pulse per CE change and per OE fall, ADV fall and WE rise.
`timescale 1ns/100ps
`default_nettype none

module fsr_pin_sync
  import fsr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Raw pins
  input wire fsr_pkg::fsr_pins_t raw,
  // Clean side
  fsr_pin_if.src pins
);

  fsr_pins_t s1_q;
  fsr_pins_t s2_q;
  fsr_pins_t s3_q;
  fsr_pins_t filt_q;
  fsr_pins_t filt_d;
  fsr_pins_t agree;
  logic [3:0] fall_q;
  logic [3:0] rise_q;

  // ----------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------
  // First stage feeds only the second, so it never reaches logic while metastable
  assign agree = ~(s2_q ^ s3_q);
  assign filt_d = (agree & s3_q) | (~agree & filt_q);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_q <= `FSR_PIN_IDLE;
      s2_q <= `FSR_PIN_IDLE;
      s3_q <= `FSR_PIN_IDLE;
      filt_q <= `FSR_PIN_IDLE;
      fall_q <= 4'h0;
      rise_q <= 4'h0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      fall_q <= filt_q[3:0] & ~filt_d[3:0];
      rise_q <= ~filt_q[3:0] & filt_d[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pins.ce_n = filt_q[`FSR_PIN_CE];
  assign pins.oe_n = filt_q[`FSR_PIN_OE];
  assign pins.we_n = filt_q[`FSR_PIN_WE];
  assign pins.adv_n = filt_q[`FSR_PIN_ADV];
  assign pins.dq = filt_q[`FSR_PIN_DQ_MSB:`FSR_PIN_DQ_LSB];
  assign pins.ce_fall = fall_q[`FSR_PIN_CE];
  assign pins.ce_rise = rise_q[`FSR_PIN_CE];
  assign pins.oe_fall = fall_q[`FSR_PIN_OE];
  assign pins.adv_fall = fall_q[`FSR_PIN_ADV];
  assign pins.we_rise = rise_q[`FSR_PIN_WE];

endmodule : fsr_pin_sync

`default_nettype wire

// ===== design/fsr_status_top.sv
// Status readout path of a parallel flash command interface: command decode,
// status byte with sticky error flags, snapshot latch and data pin drive.
// Assumes the erase/program engine and the array run on CLK; bus pins are async.
//
// Overview of operation
// RL1: Read-status command makes reads return status
// RL2: Program, erase, lock entry switches to status
// RL3: Status output persists until another valid command
// RL4: Status readable in async and burst reads
// RL5: Status on low byte, upper byte zero
// RL6: Async snapshot at first of OE/CE fall
// RL7: Burst host toggles CE or ADV to refresh
// RL8: Bit 7 ready; busy shows only bit 0
// RL9: Bit 6 shows erase suspended
// RL10: Bit 5 erase fail or sequence error
// RL11: Bit 4 program fail or sequence error
// RL12: Bit 3 programming supply fell too low
// RL13: Bit 2 shows program suspended
// RL14: Bit 1 locked block hit, operation aborted
// RL15: Bit 0 factory programming in progress
// RL16: Status resets to ready, flags clear
// RL17: Sequence error in erase suspend sticks
// RL18: Host clears status before erase resume
// RL19: Error bits only set, cleared explicitly
// RL20: Clear command and reset clear status
// RL21: Suspend success shows suspend bit and ready
// RL22: Bad confirm sets bits 5,4, status mode
// RL23: Snapshot stable during its read access
`timescale 1ns/100ps
`default_nettype none

module fsr_status_top
  import fsr_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Flash bus pins
  input wire logic CE_N,
  input wire logic OE_N,
  input wire logic WE_N,
  input wire logic ADV_N,
  input wire fsr_pkg::fsr_word_t DQ_I,
  output var fsr_pkg::fsr_word_t DQ_O,
  output var logic DQ_OE_N,
  // Array and read configuration
  input wire fsr_pkg::fsr_word_t ARRAY_DATA,
  input wire logic SYNC_READ_MODE,
  // Engine state
  input wire logic ENGINE_BUSY,
  input wire logic ERASE_PAUSED,
  input wire logic PROGRAM_PAUSED,
  input wire logic FACTORY_BUSY,
  input wire logic ERASE_FAIL_EVT,
  input wire logic PROG_FAIL_EVT,
  input wire logic SUPPLY_LOW_EVT,
  input wire logic LOCK_ABORT_EVT,
  // Engine commands
  output var logic START_PROGRAM,
  output var logic START_PROTECT,
  output var logic START_ERASE,
  output var logic START_LOCK,
  output var logic START_FACTORY,
  output var logic START_CONFIG,
  output var logic SUSPEND_REQ,
  output var logic RESUME_REQ,
  output var fsr_pkg::fsr_word_t CMD_DATA,
  output var logic STATUS_MODE
);

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  fsr_pin_if pins ();
  fsr_pins_t raw_pins;

  assign raw_pins = {DQ_I, ADV_N, WE_N, OE_N, CE_N};

  fsr_pin_sync u_sync (
    .clk(CLK),
    .resetn(RESETN),
    .raw(raw_pins),
    .pins(pins)
  );

  // ----------------------------------------------------------------
  // Command byte decode
  // ----------------------------------------------------------------
  logic [7:0] cmd;
  logic wr;
  logic is_rs;
  logic is_ra;
  logic is_clr;
  logic is_prog;
  logic is_prot;
  logic is_erase;
  logic is_lock_setup;
  logic is_factory;
  logic is_confirm;
  logic is_susp;
  logic is_lock_op;
  logic is_config;
  logic any_paused;

  assign cmd = pins.dq[7:0];
  // Writes count only with the chip selected
  assign wr = pins.we_rise & ~pins.ce_n;
  assign is_rs = fsr_is_code(cmd, `FSR_CMD_READ_STATUS);
  assign is_ra = fsr_is_code(cmd, `FSR_CMD_READ_ARRAY);
  assign is_clr = fsr_is_code(cmd, `FSR_CMD_CLEAR_STATUS);
  assign is_prog = fsr_is_code(cmd, `FSR_CMD_PROG_SETUP);
  assign is_prot = fsr_is_code(cmd, `FSR_CMD_PROT_SETUP);
  assign is_erase = fsr_is_code(cmd, `FSR_CMD_ERASE_SETUP);
  assign is_lock_setup = fsr_is_code(cmd, `FSR_CMD_LOCK_SETUP);
  assign is_factory = fsr_is_code(cmd, `FSR_CMD_FACTORY_SETUP);
  assign is_confirm = fsr_is_code(cmd, `FSR_CMD_CONFIRM);
  assign is_susp = fsr_is_code(cmd, `FSR_CMD_SUSPEND);
  assign is_config = fsr_is_code(cmd, `FSR_CMD_CONFIG);
  assign is_lock_op = fsr_is_code(cmd, `FSR_CMD_LOCK) | is_confirm |
    fsr_is_code(cmd, `FSR_CMD_LOCK_DOWN);
  assign any_paused = ERASE_PAUSED | PROGRAM_PAUSED;

  // ----------------------------------------------------------------
  // Command decoder state machine
  // ----------------------------------------------------------------
  fsr_dec_e state_q;
  fsr_dec_e state_d;
  logic status_mode_q;
  logic status_mode_d;
  logic seq_err;
  logic clr_req;
  logic start_prog_d;
  logic start_prot_d;
  logic start_erase_d;
  logic start_lock_d;
  logic start_factory_d;
  logic start_config_d;
  logic susp_d;
  logic resume_d;
  fsr_word_t cmd_data_d;

  always_comb begin
    state_d = state_q;
    status_mode_d = status_mode_q;
    seq_err = 1'b0;
    clr_req = 1'b0;
    start_prog_d = 1'b0;
    start_prot_d = 1'b0;
    start_erase_d = 1'b0;
    start_lock_d = 1'b0;
    start_factory_d = 1'b0;
    start_config_d = 1'b0;
    susp_d = 1'b0;
    resume_d = 1'b0;
    cmd_data_d = CMD_DATA;
    if (wr) begin
      unique case (state_q)
        DS_IDLE: begin
          if (ENGINE_BUSY) begin
            // While the engine runs only status read and suspend are heard
            if (is_rs) begin
              // RL1: status on request
              status_mode_d = 1'b1;
            end else if (is_susp) begin
              susp_d = 1'b1;
              status_mode_d = 1'b1;
            end
          end else if (is_rs) begin
            // RL1: status on request
            status_mode_d = 1'b1;
          end else if (is_ra) begin
            // RL3: leave status mode
            status_mode_d = 1'b0;
          end else if (is_clr) begin
            // RL20: clear on command
            clr_req = 1'b1;
          end else if (is_prog) begin
            state_d = DS_PROG;
          end else if (is_prot) begin
            state_d = DS_PROT;
          end else if (is_erase) begin
            state_d = DS_ERASE;
          end else if (is_lock_setup) begin
            state_d = DS_LOCK;
          end else if (is_factory) begin
            state_d = DS_FACTORY;
          end else if (is_confirm && any_paused) begin
            resume_d = 1'b1;
            status_mode_d = 1'b1;
          end
        end
        DS_PROG: begin
          // RL2: program accepted, status out
          start_prog_d = 1'b1;
          cmd_data_d = pins.dq;
          status_mode_d = 1'b1;
          state_d = DS_IDLE;
        end
        DS_PROT: begin
          start_prot_d = 1'b1;
          cmd_data_d = pins.dq;
          status_mode_d = 1'b1;
          state_d = DS_IDLE;
        end
        DS_ERASE: begin
          // RL2: erase accepted, status out
          // RL22: bad confirm is a sequence error
          start_erase_d = is_confirm;
          seq_err = ~is_confirm;
          cmd_data_d = pins.dq;
          status_mode_d = 1'b1;
          state_d = DS_IDLE;
        end
        DS_LOCK: begin
          cmd_data_d = pins.dq;
          state_d = DS_IDLE;
          if (is_lock_op) begin
            // RL2: lock accepted, status out
            start_lock_d = 1'b1;
            status_mode_d = 1'b1;
          end else if (is_config) begin
            // Configuration write returns reads to the array
            start_config_d = 1'b1;
            status_mode_d = 1'b0;
          end else begin
            // RL22: bad second cycle
            seq_err = 1'b1;
            status_mode_d = 1'b1;
          end
        end
        DS_FACTORY: begin
          // RL22: bad confirm is a sequence error
          start_factory_d = is_confirm;
          seq_err = ~is_confirm;
          cmd_data_d = pins.dq;
          status_mode_d = 1'b1;
          state_d = DS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sticky error flags
  // ----------------------------------------------------------------
  // Order: erase fail, program fail, supply low, locked-block abort
  logic [3:0] sticky_q;
  logic [3:0] sticky_d;
  logic [3:0] sticky_set;

  // RL10: erase fail or sequence error
  // RL11: program fail or sequence error
  // RL17: error sticks through suspend
  assign sticky_set = {ERASE_FAIL_EVT | seq_err, PROG_FAIL_EVT | seq_err,
    SUPPLY_LOW_EVT, LOCK_ABORT_EVT};
  // RL19: set only, set beats clear
  assign sticky_d = (sticky_q & ~{4{clr_req}}) | sticky_set;

  // ----------------------------------------------------------------
  // Live status byte
  // ----------------------------------------------------------------
  logic engine_ready_flag;
  logic erase_paused_flag;
  logic erase_fail_flag;
  logic program_fail_flag;
  logic supply_low_flag;
  logic program_paused_flag;
  logic locked_block_abort_flag;
  logic factory_prog_busy_flag;
  fsr_status_t status_live;

  // RL8: bits 6..1 hidden while busy
  assign engine_ready_flag = ~ENGINE_BUSY;
  // RL9: erase suspend level
  // RL21: suspend shows with ready
  assign erase_paused_flag = ERASE_PAUSED & engine_ready_flag;
  assign erase_fail_flag = sticky_q[3] & engine_ready_flag;
  assign program_fail_flag = sticky_q[2] & engine_ready_flag;
  // RL12: supply fault flag
  assign supply_low_flag = sticky_q[1] & engine_ready_flag;
  // RL13: program suspend level
  assign program_paused_flag = PROGRAM_PAUSED & engine_ready_flag;
  // RL14: locked block abort flag
  assign locked_block_abort_flag = sticky_q[0] & engine_ready_flag;
  // RL15: factory programming progress
  assign factory_prog_busy_flag = FACTORY_BUSY;

  assign status_live[`FSR_STAT_READY] = engine_ready_flag;
  assign status_live[`FSR_STAT_ERASE_PAUSED] = erase_paused_flag;
  assign status_live[`FSR_STAT_ERASE_FAIL] = erase_fail_flag;
  assign status_live[`FSR_STAT_PROG_FAIL] = program_fail_flag;
  assign status_live[`FSR_STAT_SUPPLY_LOW] = supply_low_flag;
  assign status_live[`FSR_STAT_PROG_PAUSED] = program_paused_flag;
  assign status_live[`FSR_STAT_LOCK_ABORT] = locked_block_abort_flag;
  assign status_live[`FSR_STAT_FACTORY_BUSY] = factory_prog_busy_flag;

  // ----------------------------------------------------------------
  // Snapshot latch
  // ----------------------------------------------------------------
  logic armed_q;
  logic armed_d;
  logic cap_async;
  logic cap_sync;
  logic capture;
  logic rearm;
  fsr_status_t snap_q;
  fsr_status_t snap_d;

  // RL6: first falling edge only
  // Rearm needs the access to end, so a later OE or CE fall cannot resample
  assign cap_async = armed_q & (pins.oe_fall | pins.ce_fall);
  assign rearm = (pins.ce_n & pins.oe_n) | pins.ce_rise;
  assign armed_d = cap_async ? 1'b0 : (rearm | armed_q);
  // RL7: burst refresh needs toggle
  assign cap_sync = pins.ce_fall | pins.adv_fall;
  // RL4: both read modes
  assign capture = SYNC_READ_MODE ? cap_sync : cap_async;
  // RL23: held between captures
  assign snap_d = capture ? status_live : snap_q;

  // ----------------------------------------------------------------
  // Data pin drive
  // ----------------------------------------------------------------
  logic reading;
  fsr_word_t dq_d;

  assign reading = ~pins.ce_n & ~pins.oe_n;
  // RL5: upper byte forced zero
  // RL3: status while in status mode
  assign dq_d = status_mode_q ? {`FSR_UPPER_ZERO, snap_d} : ARRAY_DATA;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      state_q <= DS_IDLE;
      status_mode_q <= 1'b0;
      // RL16: ready, flags clear
      // RL20: reset clears status
      sticky_q <= `FSR_STICKY_CLEAR;
      snap_q <= `FSR_STAT_RESET;
      armed_q <= 1'b1;
    end else begin
      state_q <= state_d;
      status_mode_q <= status_mode_d;
      sticky_q <= sticky_d;
      snap_q <= snap_d;
      armed_q <= armed_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      DQ_O <= 16'h0000;
      DQ_OE_N <= 1'b1;
      STATUS_MODE <= 1'b0;
    end else begin
      DQ_O <= dq_d;
      DQ_OE_N <= ~reading;
      STATUS_MODE <= status_mode_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      START_PROGRAM <= 1'b0;
      START_PROTECT <= 1'b0;
      START_ERASE <= 1'b0;
      START_LOCK <= 1'b0;
      START_FACTORY <= 1'b0;
      START_CONFIG <= 1'b0;
      SUSPEND_REQ <= 1'b0;
      RESUME_REQ <= 1'b0;
      CMD_DATA <= 16'h0000;
    end else begin
      START_PROGRAM <= start_prog_d;
      START_PROTECT <= start_prot_d;
      START_ERASE <= start_erase_d;
      START_LOCK <= start_lock_d;
      START_FACTORY <= start_factory_d;
      START_CONFIG <= start_config_d;
      SUSPEND_REQ <= susp_d;
      RESUME_REQ <= resume_d;
      CMD_DATA <= cmd_data_d;
    end
  end

endmodule : fsr_status_top

`default_nettype wire

// ===== tb/fsr_status_props.sv
// Concurrent checks on the status readout top-level ports.
// Assumes binding into fsr_status_top; one clock, synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module fsr_status_props
  import fsr_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Bus side
  input wire logic WE_N,
  input wire fsr_pkg::fsr_word_t DQ_O,
  input wire logic DQ_OE_N,
  input wire logic SYNC_READ_MODE,
  // Engine side
  input wire logic ENGINE_BUSY,
  input wire logic ERASE_PAUSED,
  input wire logic PROGRAM_PAUSED,
  input wire logic FACTORY_BUSY,
  input wire logic START_PROGRAM,
  input wire logic START_ERASE,
  input wire logic START_LOCK,
  input wire logic START_CONFIG,
  input wire logic SUSPEND_REQ,
  input wire logic STATUS_MODE
);
  // ----------------------------------------------------------------
  // Helper ages
  // ----------------------------------------------------------------
  logic [3:0] lvl_q;
  logic [3:0] lvl_age_q;
  logic [3:0] we_age_q;
  wire logic [3:0] lvl_d = {ENGINE_BUSY, ERASE_PAUSED, PROGRAM_PAUSED, FACTORY_BUSY};
  wire logic lvl_old = lvl_age_q == 4'hf;

  // Ages saturate, so long quiet spells do not wrap
  always_ff @(posedge CLK) begin
    lvl_q <= lvl_d;
    if (!RESETN) begin
      lvl_age_q <= 4'h0;
      we_age_q <= 4'h0;
    end else begin
      lvl_age_q <= (lvl_d != lvl_q) ? 4'h0 : lvl_age_q + {3'h0, !lvl_old};
      we_age_q <= !WE_N ? 4'h0 : we_age_q + {3'h0, we_age_q != 4'hf};
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  a_upper_zero: assert property (
    !DQ_OE_N && STATUS_MODE && $past(STATUS_MODE) |-> DQ_O[15:8] == 8'h00)
    else $error("upper byte not zero in status read");
  a_busy_hides: assert property (
    !DQ_OE_N && STATUS_MODE && $past(STATUS_MODE) && !DQ_O[7] |-> DQ_O[6:1] == 6'h00)
    else $error("busy status shows flags");
  a_level_bits: assert property (
    $fell(DQ_OE_N) && STATUS_MODE && lvl_old |-> DQ_O[7] == !ENGINE_BUSY && DQ_O[0] == FACTORY_BUSY)
    else $error("ready or factory bit wrong");
  a_pause_bits: assert property (
    $fell(DQ_OE_N) && STATUS_MODE && lvl_old && !ENGINE_BUSY
    |-> DQ_O[6] == ERASE_PAUSED && DQ_O[2] == PROGRAM_PAUSED)
    else $error("suspend bits wrong");
  a_start_mode: assert property (
    START_PROGRAM || START_ERASE || START_LOCK |-> ##[0:1] STATUS_MODE)
    else $error("start without status mode");
  a_config_exit: assert property (
    START_CONFIG |-> ##[0:1] !STATUS_MODE)
    else $error("config kept status mode");
  a_mode_cause: assert property (
    $past(RESETN) && !$stable(STATUS_MODE) |-> we_age_q < 4'hc)
    else $error("mode change without write");
  a_reset_vals: assert property (
    $rose(RESETN) |-> DQ_OE_N && !STATUS_MODE && DQ_O == 16'h0000 && !START_ERASE)
    else $error("outputs not at reset values");
  a_snap_stable: assert property (
    !DQ_OE_N && $past(!DQ_OE_N) && STATUS_MODE && $past(STATUS_MODE) && !SYNC_READ_MODE
    |-> $stable(DQ_O))
    else $error("snapshot moved during read");

  c_erase_start: cover property (START_ERASE);
  c_burst_read: cover property ($fell(DQ_OE_N) && STATUS_MODE && SYNC_READ_MODE);
  c_suspend: cover property (SUSPEND_REQ);
endmodule : fsr_status_props

bind fsr_status_top fsr_status_props chk_u (.*);

`default_nettype wire

// ===== tb/fsr_host_model.sv
// Host side of the flash bus: command writes and status reads on the pins.
// Assumes pins change at the falling clock edge, far from the sampling edge.
`timescale 1ns/100ps
`default_nettype none

module fsr_host_model
  import fsr_pkg::*;
(
  // Clock
  input wire logic CLK,
  // Bus pins
  output var logic CE_N,
  output var logic OE_N,
  output var logic WE_N,
  output var logic ADV_N,
  output var fsr_pkg::fsr_word_t DQ_I,
  input wire fsr_pkg::fsr_word_t DQ_O,
  input wire logic DQ_OE_N
);
  initial begin
    {CE_N, OE_N, WE_N, ADV_N} = 4'hf;
    DQ_I = 16'h0000;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // command write, no address needed
  task automatic wr(input logic [7:0] code);
    @(negedge CLK);
    CE_N = 1'b0;
    DQ_I = {8'h00, code};
    WE_N = 1'b0;
    repeat (4) @(negedge CLK);
    WE_N = 1'b1;
    repeat (4) @(negedge CLK);
    CE_N = 1'b1;
    // Stale data must not linger
    DQ_I = ~DQ_I;
    repeat (4) @(negedge CLK);
  endtask : wr

  task automatic rd(input bit adv, output fsr_word_t first, output fsr_word_t last,
    output bit ok);
    int n = 0;
    @(negedge CLK);
    CE_N = 1'b0;
    OE_N = 1'b0;
    ADV_N = !adv;
    while (DQ_OE_N !== 1'b0 && n < 20) begin
      @(negedge CLK);
      n++;
    end
    ok = n < 20;
    first = DQ_O;
    repeat (6) @(negedge CLK);
    last = DQ_O;
    {CE_N, OE_N, ADV_N} = 3'b111;
    repeat (6) @(negedge CLK);
  endtask : rd
endmodule : fsr_host_model

`default_nettype wire

// ===== tb/test_flash_status_readout.sv
// Self-checking bench for the flash status readout path.
// Assumes the host model on the pins and the checker bound to the top ports.
`timescale 1ns/100ps
`default_nettype none
`include "fsr_map.svh"

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end

module test_flash_status_readout;
  import fsr_pkg::*;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic CE_N, OE_N, WE_N, ADV_N, DQ_OE_N, SYNC_READ_MODE, STATUS_MODE;
  logic ENGINE_BUSY, ERASE_PAUSED, PROGRAM_PAUSED, FACTORY_BUSY;
  logic ERASE_FAIL_EVT, PROG_FAIL_EVT, SUPPLY_LOW_EVT, LOCK_ABORT_EVT;
  logic START_PROGRAM, START_ERASE, START_LOCK, START_CONFIG, SUSPEND_REQ, RESUME_REQ;
  fsr_word_t DQ_I, DQ_O, ARRAY_DATA;
  int checked = 0, mismatches = 0, n_start = 0, n_susp = 0, n_res = 0;
  logic [15:0] lfsr_q = 16'h0005;
  logic [7:0] setup_tab [4] = '{`FSR_CMD_PROG_SETUP, `FSR_CMD_ERASE_SETUP,
    `FSR_CMD_LOCK_SETUP, `FSR_CMD_LOCK_SETUP};
  logic [7:0] second_tab [4] = '{8'h3c, `FSR_CMD_CONFIRM, `FSR_CMD_LOCK, `FSR_CMD_CONFIG};

  fsr_status_top dut_u (.*, .START_PROTECT(), .START_FACTORY(), .CMD_DATA());
  fsr_host_model host_u (.*);

  always #5 CLK = ~CLK;

  always @(posedge CLK) begin
    if ((START_PROGRAM | START_ERASE | START_LOCK | START_CONFIG) === 1'b1) n_start++;
    if (SUSPEND_REQ === 1'b1) n_susp++;
    if (RESUME_REQ === 1'b1) n_res++;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  // Engine levels v = {busy, erase paused, program paused, factory busy}
  function automatic fsr_word_t exp_st(input logic [3:0] v, input logic [3:0] s);
    if (v[3]) return {15'h0000, v[0]};
    return {8'h00, 1'b1, v[2], s[3], s[2], s[1], v[1], s[0], v[0]};
  endfunction : exp_st

  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task automatic rd_chk(input fsr_word_t exp, input string nm, input bit adv);
    fsr_word_t d0, d1;
    bit ok;
    host_u.rd(adv, d0, d1, ok);
    if (!ok) begin
      mismatches++;
      finish_test();
    end else `CHK(nm, exp, d0)
  endtask : rd_chk

  task automatic set_eng(input logic [3:0] v);
    @(negedge CLK);
    {ENGINE_BUSY, ERASE_PAUSED, PROGRAM_PAUSED, FACTORY_BUSY} = v;
  endtask : set_eng

  task automatic pulse_evt(input logic [3:0] e);
    @(negedge CLK);
    {ERASE_FAIL_EVT, PROG_FAIL_EVT, SUPPLY_LOW_EVT, LOCK_ABORT_EVT} = e;
    @(negedge CLK);
    {ERASE_FAIL_EVT, PROG_FAIL_EVT, SUPPLY_LOW_EVT, LOCK_ABORT_EVT} = 4'h0;
  endtask : pulse_evt

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    fsr_word_t d0, d1;
    bit ok;
    logic [3:0] v, e, sf;
    {ENGINE_BUSY, ERASE_PAUSED, PROGRAM_PAUSED, FACTORY_BUSY} = 4'h0;
    {ERASE_FAIL_EVT, PROG_FAIL_EVT, SUPPLY_LOW_EVT, LOCK_ABORT_EVT} = 4'h0;
    SYNC_READ_MODE = 1'b0;
    ARRAY_DATA = 16'ha5c3;
    sf = 4'h0;
    repeat (6) @(negedge CLK);
    RESETN = 1'b1;
    repeat (4) @(negedge CLK);
    rd_chk(16'ha5c3, "array word", 0);
    host_u.wr(`FSR_CMD_READ_STATUS);
    rd_chk(16'h0080, "reset status", 0);
    for (int i = 0; i < 16; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      v = lfsr_q[3:0];
      e = lfsr_q[7:4];
      set_eng(v);
      pulse_evt(e);
      sf = sf | e;
      if (lfsr_q[8] && !v[3]) begin
        host_u.wr(`FSR_CMD_CLEAR_STATUS);
        sf = 4'h0;
      end
      rd_chk(exp_st(v, sf), "random status", 0);
    end
    set_eng(4'h0);
    host_u.wr(`FSR_CMD_CLEAR_STATUS);
    for (int i = 0; i < 4; i++) begin
      host_u.wr(`FSR_CMD_READ_ARRAY);
      rd_chk(16'ha5c3, "array exit", 0);
      v = 4'(n_start);
      host_u.wr(setup_tab[i]);
      host_u.wr(second_tab[i]);
      `CHK("start pulses", v + 4'h1, 4'(n_start))
      rd_chk(i < 3 ? 16'h0080 : 16'ha5c3, "seq mode", 0);
    end
    host_u.wr(`FSR_CMD_READ_STATUS);
    set_eng(4'h8);
    fork
      host_u.rd(1'b0, d0, d1, ok);
      begin
        repeat (10) @(negedge CLK);
        ENGINE_BUSY = 1'b0;
      end
    join
    `CHK("held snapshot", d0, d1)
    `CHK("busy snapshot", 16'h0000, d0)
    rd_chk(16'h0080, "fresh snapshot", 0);
    set_eng(4'h8);
    host_u.wr(`FSR_CMD_SUSPEND);
    `CHK("suspend pulses", 1, n_susp)
    set_eng(4'h4);
    rd_chk(exp_st(4'h4, 4'h0), "erase suspended", 0);
    host_u.wr(`FSR_CMD_ERASE_SETUP);
    host_u.wr(`FSR_CMD_READ_ARRAY);
    rd_chk(exp_st(4'h4, 4'hc), "sequence error", 0);
    rd_chk(exp_st(4'h4, 4'hc), "error kept", 0);
    host_u.wr(`FSR_CMD_CLEAR_STATUS);
    host_u.wr(`FSR_CMD_CONFIRM);
    `CHK("resume pulses", 1, n_res)
    set_eng(4'h8);
    pulse_evt(4'h8);
    set_eng(4'h0);
    rd_chk(exp_st(4'h0, 4'h8), "resumed erase fail", 0);
    SYNC_READ_MODE = 1'b1;
    for (int i = 0; i < 2; i++) begin
      set_eng({3'b000, i[0]});
      rd_chk(exp_st({3'b000, i[0]}, 4'h8), "burst status", 1);
    end
    finish_test();
  end
endmodule : test_flash_status_readout

`default_nettype wire
